// File: hw/lsu_agen_defs.vh
// constants for the load/store address generation block
// assumes a 32-bit core with sixteen registers, 13 = stack, 15 = program counter
`ifndef LSU_AGEN_DEFS_VH
`define LSU_AGEN_DEFS_VH
// addressing modes
`define MODE_OFFSET   2'h0
`define MODE_PRE      2'h1
`define MODE_POST     2'h2
`define MODE_REGOFF   2'h3
// transfer sizes
`define SIZE_BYTE     3'h0
`define SIZE_HALF     3'h1
`define SIZE_WORD     3'h2
`define SIZE_DUAL     3'h3
// register numbers
`define REG_SP        4'hD
`define REG_PC        4'hF
// offset limits, in bytes, and the largest register offset shift
`define OFF_NEG_MAX   13'h00FF
`define OFF_POS_BIG   13'h0FFF
`define OFF_POS_IDX   13'h00FF
`define OFF_DUAL_MAX  13'h03FC
`define SHIFT_MAX     2'h3
// sequencer states
`define ST_IDLE       2'h0
`define ST_ACC1       2'h1
`define ST_ACC2       2'h2
`define ST_DONE       2'h3
`endif

// File: hw/load_extend.v
// load data extender: byte/halfword zero or sign extension to a word
// assumes data arrives right-aligned in the low lanes
module load_extend #(
   parameter W = 32
) (
   // data
   input  wire [W-1:0] raw_i,
   input  wire [2:0]   size_i,
   input  wire         signed_i,
   output reg  [W-1:0] ext_o
);
`include "lsu_agen_defs.vh"
   always @* begin
      case (size_i)
         `SIZE_BYTE: ext_o = {{(W-8){signed_i & raw_i[7]}}, raw_i[7:0]};
         `SIZE_HALF: ext_o = {{(W-16){signed_i & raw_i[15]}}, raw_i[15:0]};
         default:    ext_o = raw_i;
      endcase
   end
endmodule // load_extend

// File: hw/load_store_address_generation.v
// load/store address generation, writeback and operand checking
// assumes decode presents one instruction at a time with a start pulse and
// the memory answers each access with a one-cycle done pulse
//
// Behaviour
// - loads fill one or two registers; stores write one or two values
// - offset mode: address is base plus/minus immediate, base kept
// - pre-indexed: address is base plus/minus immediate, written back too
// - post-indexed: access at base, then base plus/minus immediate written back
// - single offsets -255..4095 in offset mode, -255..255 when indexed
// - dual offsets are multiples of four within -1020..+1020
// - byte, halfword, word and dual sizes; signed byte and halfword loads
// - unsigned loads zero-extend, signed loads sign-extend to 32 bits
// - word load into program counter branches with bit 0 cleared
// - condition flags are never changed by these forms
// - register offset: base plus offset register shifted 0..3, no writeback
module load_store_address_generation #(
   parameter W = 32
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         reset_i,
   // decoded instruction
   input  wire         start_i,
   input  wire         is_load_i,
   input  wire [1:0]   mode_i,
   input  wire [2:0]   size_i,
   input  wire         signed_i,
   input  wire         add_i,
   input  wire [12:0]  imm_i,
   input  wire [1:0]   shift_i,
   input  wire [3:0]   base_reg_i,
   input  wire [3:0]   data_reg_i,
   input  wire [3:0]   second_data_reg_i,
   input  wire [3:0]   offset_reg_i,
   input  wire         in_cond_block_i,
   input  wire         last_in_block_i,
   // register file operands
   input  wire [W-1:0] base_val_i,
   input  wire [W-1:0] offset_val_i,
   input  wire [W-1:0] data_val_i,
   input  wire [W-1:0] second_data_val_i,
   // memory system
   output reg          mem_req_o,
   output reg          mem_write_o,
   output reg  [W-1:0] mem_addr_o,
   output reg  [W-1:0] mem_wdata_o,
   output reg  [2:0]   mem_size_o,
   input  wire         mem_done_i,
   input  wire [W-1:0] mem_rdata_i,
   // register file writes
   output reg          rf_we_o,
   output reg  [3:0]   rf_waddr_o,
   output reg  [W-1:0] rf_wdata_o,
   output reg          wb_we_o,
   output reg  [3:0]   wb_waddr_o,
   output reg  [W-1:0] wb_wdata_o,
   // branch, status
   output reg          branch_o,
   output reg  [W-1:0] branch_target_o,
   output reg          flags_we_o,
   output reg          busy_o,
   output reg          done_o,
   output reg          illegal_o,
   output reg          unpredictable_o
);
`include "lsu_agen_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// operand checks and address arithmetic

   wire         dual     = (size_i == `SIZE_DUAL);
   wire         indexed  = (mode_i == `MODE_PRE) || (mode_i == `MODE_POST);
   wire         regoff   = (mode_i == `MODE_REGOFF);
   wire         word     = (size_i == `SIZE_WORD);
   wire         t_sp     = (data_reg_i == `REG_SP);
   wire         t_pc     = (data_reg_i == `REG_PC);
   wire         t2_bad   = (second_data_reg_i == `REG_SP) || (second_data_reg_i == `REG_PC);
   wire [12:0]  off_lim  = dual ? `OFF_DUAL_MAX :
                           (add_i ? ((mode_i == `MODE_OFFSET) ? `OFF_POS_BIG : `OFF_POS_IDX)
                                  : `OFF_NEG_MAX);
   wire         off_bad  = !regoff && ((imm_i > off_lim) ||
                           (dual && (imm_i[1:0] != 2'h0)));
   // shape errors: no signed stores, no dual register offset, shift 0..3
   wire         shape_bad = (signed_i && (!is_load_i || word || dual)) ||
                            (regoff && dual) || (shift_i > `SHIFT_MAX);
   wire         base_clash = indexed && ((base_reg_i == data_reg_i) ||
                             (dual && (base_reg_i == second_data_reg_i)));
   wire         ld_bad   = is_load_i && (((t_sp || t_pc) && !word) ||
                           (dual && (t2_bad || (data_reg_i == second_data_reg_i))));
   wire         st_bad   = !is_load_i && ((t_sp && !word) || t_pc ||
                           (base_reg_i == `REG_PC) || (dual && t2_bad));
   wire         ro_bad   = regoff && ((offset_reg_i == `REG_SP) ||
                           (offset_reg_i == `REG_PC) || (base_reg_i == `REG_PC));
   wire         blk_bad  = is_load_i && t_pc && word && in_cond_block_i &&
                           !last_in_block_i;
   wire         unpred   = base_clash || ld_bad || st_bad || ro_bad || blk_bad;
   wire         illeg    = off_bad || shape_bad;

   wire [W-1:0] imm_ext  = {{(W-13){1'b0}}, imm_i};
   wire [W-1:0] off_amt  = regoff ? (offset_val_i << shift_i) : imm_ext;
   wire [W-1:0] sum      = (add_i || regoff) ? (base_val_i + off_amt)
                                             : (base_val_i - off_amt);
   wire [W-1:0] first_addr = (mode_i == `MODE_POST) ? base_val_i : sum;

////////////////////////////////////////////////////////////////////////////////
// access sequencer

   reg [1:0]   state_reg, state_next;
   reg         load_reg;
   reg         dual_reg;
   reg         sgn_reg;
   reg [2:0]   size_reg;
   reg [3:0]   t_reg, t2_reg, n_reg;
   reg [W-1:0] addr_reg;
   reg [W-1:0] d2_reg;
   reg         wb_pend_reg;
   reg [W-1:0] wb_val_reg;
   wire [W-1:0] ext_data;

   load_extend #(.W(W)) u_extend (
      .raw_i    (mem_rdata_i),
      .size_i   (size_reg),
      .signed_i (sgn_reg),
      .ext_o    (ext_data)
   );

   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_IDLE: if (start_i && !illeg && !unpred) state_next = `ST_ACC1;
         `ST_ACC1: if (mem_done_i) state_next = dual_reg ? `ST_ACC2 : `ST_DONE;
         `ST_ACC2: if (mem_done_i) state_next = `ST_DONE;
         `ST_DONE: state_next = `ST_IDLE;
         default:  state_next = `ST_IDLE;
      endcase
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         state_reg       <= `ST_IDLE;
         load_reg        <= 1'b0;
         dual_reg        <= 1'b0;
         sgn_reg         <= 1'b0;
         size_reg        <= `SIZE_WORD;
         t_reg           <= 4'h0;
         t2_reg          <= 4'h0;
         n_reg           <= 4'h0;
         addr_reg        <= {W{1'b0}};
         d2_reg          <= {W{1'b0}};
         wb_pend_reg     <= 1'b0;
         wb_val_reg      <= {W{1'b0}};
         mem_req_o       <= 1'b0;
         mem_write_o     <= 1'b0;
         mem_addr_o      <= {W{1'b0}};
         mem_wdata_o     <= {W{1'b0}};
         mem_size_o      <= `SIZE_WORD;
         rf_we_o         <= 1'b0;
         rf_waddr_o      <= 4'h0;
         rf_wdata_o      <= {W{1'b0}};
         wb_we_o         <= 1'b0;
         wb_waddr_o      <= 4'h0;
         wb_wdata_o      <= {W{1'b0}};
         branch_o        <= 1'b0;
         branch_target_o <= {W{1'b0}};
         flags_we_o      <= 1'b0;
         busy_o          <= 1'b0;
         done_o          <= 1'b0;
         illegal_o       <= 1'b0;
         unpredictable_o <= 1'b0;
      end else begin
         state_reg  <= state_next;
         flags_we_o <= 1'b0;
         rf_we_o    <= 1'b0;
         wb_we_o    <= 1'b0;
         branch_o   <= 1'b0;
         done_o     <= 1'b0;
         illegal_o  <= 1'b0;
         unpredictable_o <= 1'b0;
         case (state_reg)
            `ST_IDLE: begin
               if (start_i) begin
                  illegal_o       <= illeg;
                  unpredictable_o <= unpred;
                  if (!illeg && !unpred) begin
                     load_reg    <= is_load_i;
                     dual_reg    <= dual;
                     sgn_reg     <= signed_i;
                     size_reg    <= dual ? `SIZE_WORD : size_i;
                     t_reg       <= data_reg_i;
                     t2_reg      <= second_data_reg_i;
                     n_reg       <= base_reg_i;
                     addr_reg    <= first_addr;
                     d2_reg      <= second_data_val_i;
                     wb_pend_reg <= indexed;
                     wb_val_reg  <= sum;
                     mem_req_o   <= 1'b1;
                     mem_write_o <= !is_load_i;
                     mem_addr_o  <= first_addr;
                     mem_wdata_o <= data_val_i;
                     mem_size_o  <= dual ? `SIZE_WORD : size_i;
                     busy_o      <= 1'b1;
                  end
               end
            end
            `ST_ACC1, `ST_ACC2: begin
               if (mem_done_i) begin
                  if (load_reg) begin
                     // pc destination goes to the branch unit, not the file
                     if (state_reg == `ST_ACC1 && t_reg == `REG_PC) begin
                        branch_o        <= 1'b1;
                        branch_target_o <= {ext_data[W-1:1], 1'b0};
                     end else begin
                        rf_we_o    <= 1'b1;
                        rf_waddr_o <= (state_reg == `ST_ACC1) ? t_reg : t2_reg;
                        rf_wdata_o <= ext_data;
                     end
                  end
                  if (state_reg == `ST_ACC1 && dual_reg) begin
                     // second word sits four bytes above the first
                     mem_addr_o  <= addr_reg + 32'h00000004;
                     mem_wdata_o <= d2_reg;
                  end else begin
                     mem_req_o <= 1'b0;
                  end
               end
            end
            `ST_DONE: begin
               // writeback after the accesses, so post-index uses the old base
               wb_we_o     <= wb_pend_reg;
               wb_waddr_o  <= n_reg;
               wb_wdata_o  <= wb_val_reg;
               wb_pend_reg <= 1'b0;
               busy_o      <= 1'b0;
               done_o      <= 1'b1;
            end
            default: begin
               mem_req_o <= 1'b0;
               busy_o    <= 1'b0;
            end
         endcase
      end
   end

endmodule // load_store_address_generation

// File: sim/lsu_agen_monitor.sv
// concurrent checks on the load/store address generation ports
// assumes binding to the top module, one clock, synchronous reset
module lsu_agen_monitor (
   input wire logic        clk_i, reset_i, start_i, add_i, mem_req_o, mem_done_i,
   input wire logic        rf_we_o, wb_we_o, branch_o, flags_we_o, busy_o, done_o,
   input wire logic        illegal_o, unpredictable_o,
   input wire logic [1:0]  mode_i, shift_i,
   input wire logic [2:0]  size_i,
   input wire logic [12:0] imm_i,
   input wire logic [31:0] base_val_i, offset_val_i, mem_addr_o, mem_rdata_i,
   input wire logic [31:0] branch_target_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // busy_o drops with done_o, so a start in the done_o cycle is taken
   wire        take = start_i && !busy_o;
   wire        flag = illegal_o || unpredictable_o;
   logic [1:0] mode_q;
   always @(posedge clk_i) begin
      if (take) mode_q <= mode_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_ea;
      take && mode_i < 2'h2 |=> flag || mem_req_o && mem_addr_o == ($past(add_i) ?
         $past(base_val_i) + $past(imm_i) : $past(base_val_i) - $past(imm_i));
   endproperty
   a_ea: assert property (p_ea) else $error("offset address wrong");
   property p_post;
      take && mode_i == 2'h2 |=> flag || mem_req_o && mem_addr_o == $past(base_val_i);
   endproperty
   a_post: assert property (p_post) else $error("post address wrong");
   property p_reg;
      take && mode_i == 2'h3 |=> flag ||
         mem_addr_o == $past(base_val_i) + ($past(offset_val_i) << $past(shift_i));
   endproperty
   a_reg: assert property (p_reg) else $error("register offset address wrong");
   property p_wb;
      wb_we_o |-> mode_q == 2'h1 || mode_q == 2'h2;
   endproperty
   a_wb: assert property (p_wb) else $error("writeback in wrong mode");
   property p_rng;
      take && size_i < 3'h3 && mode_i != 2'h3 &&
         imm_i > (mode_i == 2'h0 && add_i ? 4095 : 255) |=> illegal_o;
   endproperty
   a_rng: assert property (p_rng) else $error("range not flagged");
   property p_dual;
      take && size_i == 3'h3 && mode_i != 2'h3 && (imm_i[1:0] != 2'h0 || imm_i > 1020)
         |=> illegal_o;
   endproperty
   a_dual: assert property (p_dual) else $error("dual offset not flagged");
   property p_noacc;
      flag |-> !mem_req_o;
   endproperty
   a_noacc: assert property (p_noacc) else $error("flagged form accessed");
   property p_flags;
      !flags_we_o;
   endproperty
   a_flags: assert property (p_flags) else $error("flags written");
   property p_br;
      branch_o |-> branch_target_o == ($past(mem_rdata_i) & 32'hFFFF_FFFE);
   endproperty
   a_br: assert property (p_br) else $error("branch target wrong");
   property p_step;
      mem_req_o && $past(mem_req_o) && $past(mem_done_i) |->
         mem_addr_o == $past(mem_addr_o) + 32'h4;
   endproperty
   a_step: assert property (p_step) else $error("second word address wrong");
   property p_rf;
      rf_we_o |-> $past(mem_done_i);
   endproperty
   a_rf: assert property (p_rf) else $error("register write without data");
endmodule // lsu_agen_monitor

// File: sim/lsu_mem_model.sv
// memory side model: answers each access after a chosen delay
// assumes requests hold until done; read data is only valid with done
module lsu_mem_model (
   input  wire logic        clk_i, reset_i, req_i,
   input  wire logic [31:0] addr_i, value_i,
   input  wire logic [1:0]  delay_i,
   output logic             done_o,
   output logic [31:0]      rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_reg;
   // top byte follows the address so the two dual words differ
   wire [31:0] word = value_i ^ {addr_i[7:0], 24'h0};
   // outside done the lines show the inverse, never a stale match
   assign rdata_o = done_o ? word : ~word;
   always @(posedge clk_i) begin
      if (reset_i || !req_i || done_o) begin
         cnt_reg <= 2'h0;
         done_o  <= 1'b0;
      end else if (cnt_reg == delay_i) done_o <= 1'b1;
      else cnt_reg <= cnt_reg + 2'h1;
   end
endmodule // lsu_mem_model

// File: sim/test_load_store_address_generation.sv
// table-driven bench for load/store address generation
// assumes the design sources and their header are compiled before this file
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_load_store_address_generation;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic ld; logic [1:0] md; logic [2:0] sz; logic sg, ad; logic [12:0] im;
      logic [1:0] sh; logic [3:0] rt, rn, rt2, rm; logic [31:0] mv; logic [1:0] fl;} row_t;
   // ld md sz sg ad imm sh rt rn rt2 rm memory {illegal,unpredictable}
   row_t rows [16] = '{'{1,0,2,0,1,13'hFFF,0,1,2,0,0,32'h8765_4321,0},
      '{1,1,0,1,1,13'hFF,0,3,4,0,0,32'h0000_0080,0}, '{1,2,1,1,0,13'hFF,0,3,4,0,0,32'h8001,0},
      '{1,0,1,0,0,13'hFF,0,3,4,0,0,32'hFFFF_8001,0}, '{0,2,0,0,1,13'h4,0,3,4,0,0,0,0},
      '{1,1,3,0,1,13'h3FC,0,4,6,5,0,32'h1111_2222,0}, '{0,2,3,0,0,13'h10,0,0,8,1,0,0,0},
      '{1,3,2,0,1,0,3,1,2,0,6,32'h0BAD_F00D,0}, '{0,3,1,0,0,0,0,1,2,0,6,0,0},
      '{1,0,2,0,1,13'h8,0,15,2,0,0,32'h2001,0}, '{1,0,2,0,0,13'h100,0,1,2,0,0,0,2},
      '{1,0,3,0,1,13'h3FE,0,4,2,5,0,0,2}, '{0,1,2,0,1,13'h4,0,2,2,0,0,0,1},
      '{1,3,2,0,1,0,0,1,2,0,13,0,1}, '{1,0,2,0,1,13'h8,0,15,2,0,0,32'h2001,1},
      '{1,0,2,0,1,13'h8,0,15,2,0,0,32'h2001,0}};
   logic clk_i = 0, reset_i = 1, start_i = 0, is_load_i = 0, signed_i = 0, add_i = 0;
   logic in_cond_block_i = 0, last_in_block_i = 0, hold = 0;
   logic [1:0]  mode_i = 0, shift_i = 0, dly = 0;
   logic [2:0]  size_i = 0;
   logic [12:0] imm_i = 0;
   logic [3:0]  base_reg_i = 0, data_reg_i = 0, second_data_reg_i = 0, offset_reg_i = 0;
   logic [31:0] base_val_i = 0, offset_val_i = 32'h24, data_val_i = 32'h1234_5678, mv = 0;
   logic [31:0] second_data_val_i = 32'h9ABC_DEF0;
   wire         mem_req_o, mem_write_o, rf_we_o, wb_we_o, branch_o, flags_we_o, busy_o;
   wire         done_o, illegal_o, unpredictable_o, mem_done_i;
   wire [2:0]   mem_size_o;
   wire [3:0]   rf_waddr_o, wb_waddr_o;
   wire [31:0]  mem_addr_o, mem_wdata_o, rf_wdata_o, wb_wdata_o, branch_target_o, mem_rdata_i;
   int          failures = 0, checks = 0, cyc = 0;
   load_store_address_generation dut (.clk_i, .reset_i, .start_i, .is_load_i, .mode_i,
      .size_i, .signed_i, .add_i, .imm_i, .shift_i, .base_reg_i, .data_reg_i,
      .second_data_reg_i, .offset_reg_i, .in_cond_block_i, .last_in_block_i, .base_val_i,
      .offset_val_i, .data_val_i, .second_data_val_i, .mem_req_o, .mem_write_o, .mem_addr_o,
      .mem_wdata_o, .mem_size_o, .mem_done_i, .mem_rdata_i, .rf_we_o, .rf_waddr_o,
      .rf_wdata_o, .wb_we_o, .wb_waddr_o, .wb_wdata_o, .branch_o, .branch_target_o,
      .flags_we_o, .busy_o, .done_o, .illegal_o, .unpredictable_o);
   lsu_mem_model mem (.clk_i, .reset_i, .req_i(mem_req_o), .addr_i(mem_addr_o),
      .value_i(mv), .delay_i(dly), .done_o(mem_done_i), .rdata_o(mem_rdata_i));
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ext(logic [31:0] v, logic [2:0] sz, logic sg);
      if (sz == 3'h0) return {{24{sg & v[7]}}, v[7:0]};
      if (sz == 3'h1) return {{16{sg & v[15]}}, v[15:0]};
      return v;
   endfunction
   task automatic run(input int i);
      row_t r;
      int na, nr;
      logic [31:0] ea, acc, t, mk;
      logic wbs, br, il, up;
      r = rows[i];
      {is_load_i, mode_i, size_i, signed_i, add_i, imm_i, shift_i} =
         {r.ld, r.md, r.sz, r.sg, r.ad, r.im, r.sh};
      {data_reg_i, base_reg_i, second_data_reg_i, offset_reg_i} = {r.rt, r.rn, r.rt2, r.rm};
      base_val_i = 32'h8000 + i * 256;
      mv = r.mv;
      dly = i % 3;
      start_i = 1;
      ea = base_val_i + (r.md == 3 ? offset_val_i << r.sh : r.ad ? r.im : -{19'h0, r.im});
      acc = r.md == 2 ? base_val_i : ea;
      mk = r.sz == 0 ? 32'hFF : r.sz == 1 ? 32'hFFFF : 32'hFFFF_FFFF;
      {na, nr, wbs, br, il, up} = 0;
      for (int k = 0; k < 30; k++) begin
         @(negedge clk_i);
         start_i = hold && k < 3;
         if (mem_req_o && mem_done_i) begin
            `CHK(mem_addr_o, acc + 4 * na)
            `CHK(mem_write_o, !r.ld)
            `CHK(mem_size_o, r.sz == 3 ? 3'h2 : r.sz)
            if (!r.ld) `CHK(mem_wdata_o & mk, (na ? second_data_val_i : data_val_i) & mk)
            na++;
         end
         t = acc + 4 * nr;
         t = mv ^ {t[7:0], 24'h0};
         if (rf_we_o) begin
            `CHK(rf_wdata_o, ext(t, r.sz, r.sg))
            `CHK(rf_waddr_o, nr ? r.rt2 : r.rt)
            nr++;
         end
         if (branch_o) begin
            `CHK(branch_target_o, t & 32'hFFFF_FFFE)
            br = 1;
         end
         if (wb_we_o) begin
            `CHK({wb_waddr_o, wb_wdata_o}, {r.rn, ea})
            wbs = 1;
         end
         il |= illegal_o;
         up |= unpredictable_o;
         if (done_o || il || up) break;
      end
      `CHK({il, up}, r.fl)
      `CHK(na, r.fl ? 0 : r.sz == 3 ? 2 : 1)
      `CHK(nr, r.ld && !r.fl && r.rt != 15 ? na : 0)
      `CHK(wbs, !r.fl && (r.md == 1 || r.md == 2))
      `CHK(br, r.ld && r.rt == 15 && !r.fl)
      `CHK(flags_we_o, 1'b0)
      $display("test %0d ended", i);
      repeat (2) @(negedge clk_i);
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      `CHK({mem_req_o, busy_o, done_o, rf_we_o, mem_size_o}, 7'h2)
      reset_i = 0;
      for (int i = 0; i < 14; i++) run(i);
      // conditional pc load: flagged unless last in its block
      in_cond_block_i = 1;
      run(14);
      last_in_block_i = 1;
      run(15);
      in_cond_block_i = 0;
      last_in_block_i = 0;
      // start held high through the first three busy cycles of the slow dual access
      hold = 1;
      run(5);
      end_of_test();
   end
endmodule // test_load_store_address_generation
bind load_store_address_generation lsu_agen_monitor mon (.clk_i, .reset_i, .start_i,
   .add_i, .mem_req_o, .mem_done_i, .rf_we_o, .wb_we_o, .branch_o, .flags_we_o, .busy_o,
   .done_o, .illegal_o, .unpredictable_o, .mode_i, .shift_i, .size_i, .imm_i, .base_val_i,
   .offset_val_i, .mem_addr_o, .mem_rdata_i, .branch_target_o);
